// >>> hw/ctp_top.sv
/*
 * console typewriter port: apb register file, instruction sequencer for
 * arm-keys, fetch-typed-char and print-one-char, keyboard and print links,
 * contingency indicators with mask and one level interrupt.
 * assumes a word memory that answers mem_rd within the same clock on mem_rdata,
 * and typewriter pins that are asynchronous levels.
 */
`timescale 1ns/1ps
`include "ctp_defines.svh"

module ctp_top
	import ctp_pkg::*;
#(
	parameter int NREG = 16
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic [`CTP_CHAR_W-1:0]  key_char,
	input  wire logic                    key_strobe,
	input  wire logic                    key_cancel,
	input  wire logic                    key_request,
	input  wire logic                    typer_online,
	input  wire logic                    print_done,
	output logic                         keys_armed_lamp,
	output logic                         print_start,
	output logic      [`CTP_CHAR_W-1:0]  print_char,
	output logic                         mem_rd,
	output logic      [`CTP_ADDR_W-1:0]  mem_addr,
	input  wire logic [`CTP_WORD_W-1:0]  mem_rdata,
	output logic                         irq
);

	initial begin
		if (NREG != 16) $error("ctp_top: NREG must be 16, the select fields are 4 bits");
	end

	// ---------------------------------------------------------------
	// pin synchronisers and edge detection
	// ---------------------------------------------------------------
	ctp_pins_s pins_raw;
	ctp_pins_s pins_s;
	ctp_pins_s pins_d1_q;

	assign pins_raw = '{chr: key_char, strobe: key_strobe, cancel: key_cancel,
		request: key_request, online: typer_online, print_done: print_done};

	ctp_sync #(
		.W ($bits(ctp_pins_s))
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pins_raw),
		.q       (pins_s)
	);

	// third flop for rising-edge detection on the synchronised levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_d1_q <= '0;
		end else begin
			pins_d1_q <= pins_s;
		end
	end

	logic strobe_rise;
	logic cancel_rise;
	logic request_rise;
	logic done_rise;
	logic online;

	assign strobe_rise  = pins_s.strobe & ~pins_d1_q.strobe;
	assign cancel_rise  = pins_s.cancel & ~pins_d1_q.cancel;
	assign request_rise = pins_s.request & ~pins_d1_q.request;
	assign done_rise    = pins_s.print_done & ~pins_d1_q.print_done;
	assign online       = pins_s.online;

	// ---------------------------------------------------------------
	// apb decode; zero wait states, every access done in its access phase
	// ---------------------------------------------------------------
	logic        acc;
	logic        wr;
	logic        hit_x;
	logic        hit_a;
	logic [3:0]  ridx;
	logic        mapped;
	logic        busy;
	logic        instr_refused;

	assign acc    = psel & penable;
	assign wr     = acc & pwrite;
	assign hit_x  = (paddr[7:6] == 2'b01);
	assign hit_a  = (paddr[7:6] == 2'b10);
	assign ridx   = paddr[5:2];
	assign pready = 1'b1;

	always_comb begin
		mapped = (paddr[1:0] == 2'b00) && (hit_x || hit_a ||
			paddr == `CTP_OFF_INSTR || paddr == `CTP_OFF_STATUS ||
			paddr == `CTP_OFF_CONT || paddr == `CTP_OFF_MASK ||
			paddr == `CTP_OFF_PC || paddr == `CTP_OFF_BUF ||
			paddr == `CTP_OFF_EADDR);
	end

	// an instruction written while one runs is refused, not queued
	assign instr_refused = wr && (paddr == `CTP_OFF_INSTR) && busy;
	assign pslverr       = acc && (!mapped || instr_refused);

	// ---------------------------------------------------------------
	// software-visible state
	// ---------------------------------------------------------------
	ctp_instr_s                  instr_q;
	ctp_state_e                  state_q;
	logic [`CTP_ADDR_W-1:0]      pc_q;
	logic [`CTP_CONT_W-1:0]      cont_q;
	logic [`CTP_CONT_W-1:0]      mask_q;
	logic [`CTP_CHAR_W-1:0]      buf_q;
	logic                        armed_q;
	logic                        printing_q;
	logic [`CTP_ADDR_W-1:0]      eaddr_q;
	logic [`CTP_ADDR_W-1:0]      xreg_q [NREG];
	logic [`CTP_WORD_W-1:0]      areg_q [NREG];
	logic                        issue;

	assign busy  = (state_q != ST_IDLE);
	assign issue = wr && (paddr == `CTP_OFF_INSTR) && !busy;

	// read mux; unmapped addresses read as zero, except unaligned ones in the index and arithmetic ranges
	always_comb begin
		prdata = 32'h0000_0000;
		if (hit_x) begin
			prdata[`CTP_ADDR_W-1:0] = xreg_q[ridx];
		end else if (hit_a) begin
			prdata[`CTP_WORD_W-1:0] = areg_q[ridx];
		end else begin
			case (paddr)
				`CTP_OFF_INSTR:  prdata[`CTP_WORD_W-1:0] = instr_q;
				`CTP_OFF_STATUS: begin
					prdata[`CTP_ST_BUSY]     = busy;
					prdata[`CTP_ST_ARMED]    = armed_q;
					prdata[`CTP_ST_ONLINE]   = online;
					prdata[`CTP_ST_PRINTING] = printing_q;
				end
				`CTP_OFF_CONT:   prdata[`CTP_CONT_W-1:0] = cont_q;
				`CTP_OFF_MASK:   prdata[`CTP_CONT_W-1:0] = mask_q;
				`CTP_OFF_PC:     prdata[`CTP_ADDR_W-1:0] = pc_q;
				`CTP_OFF_BUF:    prdata[`CTP_CHAR_W-1:0] = buf_q;
				`CTP_OFF_EADDR:  prdata[`CTP_ADDR_W-1:0] = eaddr_q;
				default:         prdata = 32'h0000_0000;
			endcase
		end
	end

	// instruction register latches on issue
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_q <= '0;
		end else if (issue) begin
			instr_q <= pwdata[`CTP_WORD_W-1:0];
		end
	end

	// interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= `CTP_MASK_RST;
		end else if (wr && paddr == `CTP_OFF_MASK) begin
			mask_q <= pwdata[`CTP_CONT_W-1:0];
		end
	end

	// index registers; register zero means no indexing and stays zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NREG; i++) begin
				xreg_q[i] <= '0;
			end
		end else if (wr && hit_x && ridx != 4'h0) begin
			xreg_q[ridx] <= pwdata[`CTP_ADDR_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// instruction sequencer
	// addr: form m + index, read memory (online print only)
	// ind:  indirect word arrives, its low bits are the new address
	// exec: commit the instruction's effect
	// done: closes the second instruction cycle
	// ---------------------------------------------------------------
	logic is_arm;
	logic is_fetch;
	logic is_print;
	logic is_nop;
	logic valid_op;
	logic [`CTP_ADDR_W-1:0] indexed;

	assign is_arm   = (instr_q.op == `CTP_OP_ARM);
	assign is_fetch = (instr_q.op == `CTP_OP_FETCH);
	assign is_print = (instr_q.op == `CTP_OP_PRINT);
	assign is_nop   = (instr_q.op == `CTP_OP_NOP);
	assign valid_op = is_arm | is_fetch | is_print | is_nop;
	assign indexed  = {5'h00, instr_q.m} + xreg_q[instr_q.xsel];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: if (issue) begin
					state_q <= ST_ADDR;
				end
				// offline print skips the memory read entirely
				ST_ADDR: if (is_print && online && instr_q.ind) begin
					state_q <= ST_IND;
				end else begin
					state_q <= ST_EXEC;
				end
				ST_IND:  state_q <= ST_EXEC;
				ST_EXEC: state_q <= ST_DONE;
				ST_DONE: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// memory request: one read per address step of an online print
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_rd   <= 1'b0;
			mem_addr <= '0;
			eaddr_q  <= '0;
		end else begin
			mem_rd <= 1'b0;
			if (state_q == ST_IDLE && issue) begin
				eaddr_q <= '0;
			end else if (state_q == ST_ADDR && is_print && online) begin
				mem_rd   <= 1'b1;
				mem_addr <= indexed;
				eaddr_q  <= indexed;
			end else if (state_q == ST_IND) begin
				mem_rd   <= 1'b1;
				mem_addr <= mem_rdata[`CTP_ADDR_W-1:0];
				eaddr_q  <= mem_rdata[`CTP_ADDR_W-1:0];
			end
		end
	end

	// character select: only bits 12 and 11 count, bits 14 and 13 ignored
	logic [`CTP_CHAR_W-1:0] sel_char;

	always_comb begin
		case (instr_q.fld[1:0])
			2'b11:   sel_char = mem_rdata[23:18];
			2'b10:   sel_char = mem_rdata[17:12];
			2'b01:   sel_char = mem_rdata[11:6];
			default: sel_char = mem_rdata[5:0];
		endcase
	end

	// program counter: online print skips, everything else steps by one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= `CTP_PC_RST;
		end else if (wr && paddr == `CTP_OFF_PC) begin
			pc_q <= pwdata[`CTP_ADDR_W-1:0];
		end else if (state_q == ST_EXEC) begin
			if (is_print && online) begin
				pc_q <= pc_q + 15'h0002;
			end else begin
				pc_q <= pc_q + 15'h0001;
			end
		end
	end

	// arithmetic registers; fetch adds into bits 6..1 only. the add is
	// six bits wide so its carry is simply dropped, and the program is
	// expected to have cleared those bits first
	logic [`CTP_CHAR_W-1:0] low_sum;

	assign low_sum = areg_q[instr_q.fld][`CTP_CHAR_W-1:0] + buf_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NREG; i++) begin
				areg_q[i] <= '0;
			end
		end else if (wr && hit_a) begin
			areg_q[ridx] <= pwdata[`CTP_WORD_W-1:0];
		end else if (state_q == ST_EXEC && is_fetch) begin
			// indirect flag and index are not consulted; field select picks the register
			areg_q[instr_q.fld] <= {areg_q[instr_q.fld][`CTP_WORD_W-1:`CTP_CHAR_W],
				low_sum};
		end
	end

	// ---------------------------------------------------------------
	// keyboard: armed for exactly one character; a strobe while
	// disarmed is dropped so stray keys never reach the buffer
	// ---------------------------------------------------------------
	logic key_take;

	assign key_take = armed_q && strobe_rise && online;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_q <= 1'b0;
		end else if (key_take || cancel_rise) begin
			armed_q <= 1'b0;
		end else if (state_q == ST_EXEC && is_arm) begin
			armed_q <= 1'b1;
		end
	end

	assign keys_armed_lamp = armed_q;

	// single-character buffer: last writer wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_q <= '0;
		end else if (key_take) begin
			buf_q <= pins_s.chr;
		end else if (state_q == ST_EXEC && is_print && online) begin
			buf_q <= sel_char;
		end
	end

	// print link: start pulse only from a print instruction, never from
	// a keyed character; printing ends on the mechanism's done edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			print_start <= 1'b0;
			print_char  <= '0;
			printing_q  <= 1'b0;
		end else begin
			print_start <= 1'b0;
			if (state_q == ST_EXEC && is_print && online) begin
				print_start <= 1'b1;
				print_char  <= sel_char;
				printing_q  <= 1'b1;
			end else if (done_rise) begin
				printing_q  <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// contingency indicators: sticky, write one to clear, set wins
	// ---------------------------------------------------------------
	logic [`CTP_CONT_W-1:0] cont_set;
	logic [`CTP_CONT_W-1:0] cont_clr;

	always_comb begin
		cont_set = '0;
		cont_set[`CTP_CB_TYPER] = key_take | (printing_q & done_rise);
		cont_set[`CTP_CB_KREL]  = cancel_rise;
		cont_set[`CTP_CB_KREQ]  = request_rise & online;
		cont_set[`CTP_CB_INVOP] = (state_q == ST_EXEC) & ~valid_op;
		cont_clr = '0;
		if (wr && paddr == `CTP_OFF_CONT) begin
			cont_clr = pwdata[`CTP_CONT_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cont_q <= '0;
		end else begin
			cont_q <= (cont_q & ~cont_clr) | cont_set;
		end
	end

	// level interrupt while any unmasked indicator stands
	assign irq = |(cont_q & mask_q);

endmodule : ctp_top

// >>> hw/ctp_defines.svh
/*
 * constants of the console typewriter port: register offsets, opcodes,
 * contingency bit positions, field widths and reset values.
 * assumes it is included by the package and the top module by bare name.
 */
`ifndef CTP_DEFINES_SVH
`define CTP_DEFINES_SVH

// register byte offsets
`define CTP_OFF_INSTR     8'h00
`define CTP_OFF_STATUS    8'h04
`define CTP_OFF_CONT      8'h08
`define CTP_OFF_MASK      8'h0c
`define CTP_OFF_PC        8'h10
`define CTP_OFF_BUF       8'h14
`define CTP_OFF_EADDR     8'h18
`define CTP_OFF_XREG      8'h40
`define CTP_OFF_AREG      8'h80

// opcodes, octal as printed: 66, 01, 02
`define CTP_OP_ARM        6'h36
`define CTP_OP_FETCH      6'h01
`define CTP_OP_PRINT      6'h02
`define CTP_OP_NOP        6'h00

// contingency indicator bit positions (bit position minus one)
`define CTP_CB_INVOP      1
`define CTP_CB_TYPER      2
`define CTP_CB_KREQ       3
`define CTP_CB_KREL       4
`define CTP_CONT_W        6

// status bit positions
`define CTP_ST_BUSY       0
`define CTP_ST_ARMED      1
`define CTP_ST_ONLINE     2
`define CTP_ST_PRINTING   3

`define CTP_CHAR_W        6
`define CTP_WORD_W        25
`define CTP_ADDR_W        15
`define CTP_PC_RST        15'h0000
`define CTP_MASK_RST      6'h00

`endif

// >>> hw/ctp_pkg.sv
/*
 * types of the console typewriter port: instruction layout, pin groups,
 * sequencer states.
 * assumes ctp_defines.svh is on the include path.
 */
`include "ctp_defines.svh"

package ctp_pkg;

	// 25-bit instruction word, msb is bit position 25
	typedef struct packed {
		logic       ind;
		logic [3:0] xsel;
		logic [5:0] op;
		logic [3:0] fld;
		logic [9:0] m;
	} ctp_instr_s;

	// typewriter pin group as it arrives: keyboard, online switch and print done
	typedef struct packed {
		logic [`CTP_CHAR_W-1:0] chr;
		logic                   strobe;
		logic                   cancel;
		logic                   request;
		logic                   online;
		logic                   print_done;
	} ctp_pins_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_IND,
		ST_EXEC,
		ST_DONE
	} ctp_state_e;

endpackage : ctp_pkg

// >>> hw/ctp_sync.sv
/*
 * two-flop synchroniser for a group of pin levels.
 * assumes the inputs are asynchronous levels held for several clocks.
 */
`timescale 1ns/1ps

module ctp_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	initial begin
		if (W < 1) $error("ctp_sync: W must be at least 1");
	end

	// first stage is read by the second stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : ctp_sync

// >>> tb/ctp_assertions.sv
/*
 * concurrent checks of the console typewriter port, bound to ctp_top.
 * assumes the top's port names and ctp_defines.svh on the include path.
 */
`timescale 1ns/1ps
`include "ctp_defines.svh"

module ctp_assertions (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        key_strobe,
	input wire logic        key_cancel,
	input wire logic        typer_online,
	input wire logic        keys_armed_lamp,
	input wire logic        print_start,
	input wire logic [5:0]  print_char,
	input wire logic        mem_rd,
	input wire logic        irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// an accepted instruction issue and its opcode field
	wire logic       instr_take = psel && penable && pwrite && paddr == `CTP_OFF_INSTR && !pslverr;
	wire logic [5:0] op_w       = pwdata[19:14];

	a_apb_ready: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	a_unmapped_err: assert property (psel && penable && paddr == 8'h3c |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_start_pulse: assert property (print_start |=> !print_start)
		else $error("print start longer than one cycle");
	a_char_held: assert property (!print_start |-> $stable(print_char))
		else $error("print character changed without a print");
	a_start_after_read: assert property (print_start |-> $past(mem_rd) || $past(mem_rd, 2))
		else $error("print started without a memory read");
	a_arm_lamp_on: assert property (instr_take && op_w == `CTP_OP_ARM |-> ##[1:6] keys_armed_lamp)
		else $error("arm did not light the lamp");
	a_cancel_lamp_off: assert property ($rose(key_cancel) |-> ##[1:5] !keys_armed_lamp)
		else $error("cancel did not disarm");
	a_key_lamp_off: assert property ($rose(key_strobe) && keys_armed_lamp && typer_online
		|-> ##[1:5] !keys_armed_lamp)
		else $error("typed character did not disarm");
	a_mask_irq: assert property (psel && penable && pwrite && paddr == `CTP_OFF_MASK
		&& pwdata[5:0] == 6'h00 |=> !irq)
		else $error("irq high with mask clear");
	a_fetch_no_read: assert property (instr_take && op_w == `CTP_OP_FETCH |=> !mem_rd [*4])
		else $error("fetch read memory");
	a_offline_no_start: assert property (!typer_online [*6] |-> !print_start)
		else $error("print started while offline");
endmodule : ctp_assertions

// >>> tb/ctp_typer_model.sv
/*
 * typewriter partner: keyboard strokes, buttons, online switch, print mechanism.
 * assumes the bench calls its tasks and print_start is a one-cycle pulse.
 */
`timescale 1ns/1ps

module ctp_typer_model
	import ctp_pkg::*;
(
	input  wire logic pclk,
	input  wire logic print_start,
	input  wire logic slow,
	output ctp_pins_s pins
);
	initial pins = '0;
	// the mechanism is slow, so done arrives many clocks after the start
	always @(posedge pclk) begin
		if (print_start === 1'b1) begin
			repeat (slow ? 20 : 6) @(posedge pclk);
			pins.print_done <= 1'b1;
			repeat (4) @(posedge pclk);
			pins.print_done <= 1'b0;
		end
	end
	// character set up before the strobe; released line shows the inverse
	task automatic type_char(input logic [5:0] c);
		@(posedge pclk);
		pins.chr <= c;
		repeat (2) @(posedge pclk);
		pins.strobe <= 1'b1;
		repeat (6) @(posedge pclk);
		pins.strobe <= 1'b0;
		repeat (2) @(posedge pclk);
		pins.chr <= ~c;
	endtask : type_char
	// cancel or request button, held long enough for the synchroniser
	task automatic press(input logic cancel);
		@(posedge pclk);
		if (cancel) pins.cancel <= 1'b1;
		else pins.request <= 1'b1;
		repeat (6) @(posedge pclk);
		pins.cancel <= 1'b0;
		pins.request <= 1'b0;
	endtask : press
	task automatic set_online(input logic v);
		@(posedge pclk);
		pins.online <= v;
	endtask : set_online
endmodule : ctp_typer_model

// >>> tb/tb_console_typewriter_port.sv
/*
 * self-checking bench: apb master, one-cycle word memory, typewriter partner.
 * assumes the design files, the package and the checker are compiled first.
 */
`timescale 1ns/1ps
`include "ctp_defines.svh"

module tb_console_typewriter_port
	import ctp_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, last_err, ind;
	logic        keys_armed_lamp, print_start, mem_rd, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, seed, pcx;
	logic [5:0]  print_char, c;
	logic [14:0] mem_addr;
	logic [24:0] mem_rdata, w;
	logic [24:0] mem [16];
	logic [3:0]  f, xs;
	logic [9:0]  m;
	ctp_pins_s   pins;
	int          err_total, checks, cyc, nprint, n0;

	ctp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .key_char(pins.chr), .key_strobe(pins.strobe),
		.key_cancel(pins.cancel), .key_request(pins.request), .typer_online(pins.online),
		.print_done(pins.print_done), .keys_armed_lamp(keys_armed_lamp),
		.print_start(print_start), .print_char(print_char), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .irq(irq));
	ctp_typer_model u_typer (.pclk(pclk), .print_start(print_start), .slow(slow), .pins(pins));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// memory answers from the registered address while the read stands, since
	// the design takes the word at the edge that closes that cycle
	assign mem_rdata = mem[mem_addr[3:0]];
	// cycle ceiling and print pulse count
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (print_start === 1'b1) nprint <= nprint + 1;
		if (cyc == 30000) begin
			err_total++;
			$display("mismatch at %0t: cycle limit reached", $time);
			end_of_test();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] ins(input logic ia, input logic [3:0] x,
		input logic [5:0] op, input logic [3:0] fl, input logic [9:0] a);
		return {7'h00, ia, x, op, fl, a};
	endfunction : ins
	function automatic logic [31:0] pick(input logic [24:0] x, input logic [1:0] s);
		return {26'h0, x[6 * s +: 6]};
	endfunction : pick
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) begin
			err_total++;
			$display("mismatch at %0t: no pready", $time);
		end
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// issue an instruction and poll busy, bounded
	task automatic run(input logic [31:0] i);
		int n;
		n = 0;
		apb(1'b1, `CTP_OFF_INSTR, i);
		do begin
			apb(1'b0, `CTP_OFF_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 20);
	endtask : run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	initial begin
		{psel, penable, pwrite, slow, presetn} = '0;
		paddr = '0;
		pwdata = '0;
		seed = 32'h0000000a;
		pcx = '0;
		{err_total, checks, cyc, nprint} = '0;
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			mem[i] = seed[24:0];
		end
		mem[3] = 25'd9;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `CTP_OFF_MASK, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `CTP_OFF_PC, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h3c, 32'h0);
		chk({rd[30:0], last_err}, 32'h1);
		u_typer.set_online(1'b1);
		apb(1'b1, `CTP_OFF_MASK, 32'h3e);
		$display("test reset done");
		// arm, run other work while armed, then a stroke or a cancel
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			c = seed[5:0];
			run(ins(1'b0, 4'h0, `CTP_OP_ARM, 4'h0, 10'h000));
			chk(32'(keys_armed_lamp), 32'h1);
			run(ins(1'b0, 4'h0, `CTP_OP_NOP, 4'h0, 10'h000));
			pcx += 2;
			apb(1'b0, `CTP_OFF_PC, 32'h0);
			chk(rd, pcx);
			if (k == 2) u_typer.press(1'b1);
			else u_typer.type_char(c);
			repeat (6) @(posedge pclk);
			chk(32'(keys_armed_lamp), 32'h0);
			chk(32'(irq), 32'h1);
			apb(1'b0, `CTP_OFF_CONT, 32'h0);
			chk(rd, (k == 2) ? 32'h10 : 32'h04);
			apb(1'b1, `CTP_OFF_CONT, rd);
			u_typer.type_char(~c);
			repeat (6) @(posedge pclk);
			chk(32'(irq), 32'h0);
			apb(1'b0, `CTP_OFF_BUF, 32'h0);
			if (k < 2) chk(rd, 32'(c));
		end
		chk(32'(nprint), 32'h0);
		u_typer.press(1'b0);
		repeat (6) @(posedge pclk);
		apb(1'b0, `CTP_OFF_CONT, 32'h0);
		chk(rd, 32'h08);
		apb(1'b1, `CTP_OFF_CONT, rd);
		$display("test keyboard done");
		// fetch adds into the low character, carry cut at bit 6
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			c = (k == 1) ? 6'h01 : seed[5:0];
			f = seed[9:6];
			w = seed[31:7];
			if (k == 0) w[5:0] = 6'h00;
			if (k == 1) w[5:0] = 6'h3f;
			run(ins(1'b0, 4'h0, `CTP_OP_ARM, 4'h0, 10'h000));
			u_typer.type_char(c);
			repeat (6) @(posedge pclk);
			apb(1'b1, 8'(`CTP_OFF_AREG + 4 * f), 32'(w));
			run(ins(seed[0], seed[4:1], `CTP_OP_FETCH, f, 10'h000));
			pcx += 2;
			apb(1'b0, 8'(`CTP_OFF_AREG + 4 * f), 32'h0);
			chk(rd, {7'h00, w[24:6], 6'(w[5:0] + c)});
			apb(1'b1, `CTP_OFF_CONT, 32'h3e);
		end
		$display("test fetch done");
		// every character position, indexed, one indirect, fast and slow typer
		apb(1'b1, 8'(`CTP_OFF_XREG + 8), 32'h5);
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			ind = (k == 6);
			xs = k[0] ? 4'h2 : 4'h0;
			m = ind ? 10'h003 : {7'h00, seed[2:0]};
			w = ind ? mem[9] : mem[m[3:0] + (k[0] ? 4'h5 : 4'h0)];
			slow <= k[1];
			run(ins(ind, xs, `CTP_OP_PRINT, {seed[4:3], 2'(k)}, m));
			pcx += 2;
			chk(32'(print_char), pick(w, 2'(k)));
			apb(1'b0, `CTP_OFF_BUF, 32'h0);
			chk(rd, pick(w, 2'(k)));
			apb(1'b0, `CTP_OFF_PC, 32'h0);
			chk(rd, pcx);
			apb(1'b0, `CTP_OFF_EADDR, 32'h0);
			chk(rd, ind ? 32'h9 : 32'(m[3:0] + (k[0] ? 4'h5 : 4'h0)));
			n0 = 0;
			do begin
				apb(1'b0, `CTP_OFF_CONT, 32'h0);
				n0++;
			end while (rd[2] !== 1'b1 && n0 < 40);
			chk(rd, 32'h04);
			apb(1'b1, `CTP_OFF_CONT, rd);
		end
		$display("test print done");
		// offline print only steps the counter and clears the effective address
		u_typer.set_online(1'b0);
		repeat (8) @(posedge pclk);
		// idle, disarmed, not printing, and offline seen through the synchroniser
		apb(1'b0, `CTP_OFF_STATUS, 32'h0);
		chk(rd, 32'h0);
		n0 = nprint;
		run(ins(1'b0, 4'h0, `CTP_OP_PRINT, 4'h0, 10'h001));
		pcx += 1;
		apb(1'b0, `CTP_OFF_PC, 32'h0);
		chk(rd, pcx);
		repeat (30) @(posedge pclk);
		apb(1'b0, `CTP_OFF_CONT, 32'h0);
		chk(rd, 32'h0);
		chk(32'(nprint - n0), 32'h0);
		// a masked event sets its bit but keeps irq low
		apb(1'b1, `CTP_OFF_MASK, 32'h0);
		u_typer.press(1'b1);
		repeat (6) @(posedge pclk);
		chk(32'(irq), 32'h0);
		apb(1'b0, `CTP_OFF_CONT, 32'h0);
		chk(rd, 32'h10);
		apb(1'b1, `CTP_OFF_CONT, rd);
		// unknown opcode: counter steps by one and the invalid-op bit sets
		run(ins(1'b0, 4'h0, 6'h3f, 4'h0, 10'h000));
		pcx += 1;
		apb(1'b0, `CTP_OFF_CONT, 32'h0);
		chk(rd, 32'h02);
		apb(1'b0, `CTP_OFF_PC, 32'h0);
		chk(rd, pcx);
		// a second instruction while the first still runs is refused
		apb(1'b1, `CTP_OFF_INSTR, ins(1'b0, 4'h0, `CTP_OP_NOP, 4'h0, 10'h000));
		apb(1'b1, `CTP_OFF_INSTR, ins(1'b0, 4'h0, `CTP_OP_NOP, 4'h0, 10'h000));
		chk(32'(last_err), 32'h1);
		repeat (4) @(posedge pclk);
		pcx += 1;
		apb(1'b0, `CTP_OFF_PC, 32'h0);
		chk(rd, pcx);
		$display("test offline done");
		end_of_test();
	end
endmodule : tb_console_typewriter_port

bind ctp_top ctp_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .key_strobe(key_strobe), .key_cancel(key_cancel),
	.typer_online(typer_online), .keys_armed_lamp(keys_armed_lamp),
	.print_start(print_start), .print_char(print_char), .mem_rd(mem_rd), .irq(irq));
